//--- core/lpc_sensor_core.sv
// Purpose: Conversion timing, result registers, threshold flags and interrupt pin.
// Assumes: The serial engine presents register accesses on reg_* in the clk_i domain.
// Notes:   Analog codes arrive from outside the clock domain and are double registered.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Ambient gives 12-bit result every 100 ms.
// - Ambient result readable at offsets 0x9, 0xA.
// - Proximity stores lit minus dark at 0x8.
// - Ambient and proximity timers run independently.
// - Ambient converts continuously while enabled.
// - Proximity repeats, idle set by bits 6:4.
// - Select 0 with enable gives visible sensing.
// - Select 1 routes infrared through ambient converter.
// - Emitter on 0.1 ms in 0.54 ms.
// - Drive-level bit 3 picks pulse amplitude.
// - Ambient flag sets outside threshold window.
// - Ambient flag sticks until host writes 0.
// - Proximity flag sets after consecutive high readings.
// - Proximity flag clears on low run or write.
// - Persistence counts gate each flag.
// - Combine bit selects AND or OR.
// - Both enables cleared means power down.
module lpc_sensor_core #(
  parameter int AMB_CONV_CYC   = lpc_pkg::AMB_CONV_CYC,
  parameter int NEAR_DARK_CYC  = lpc_pkg::NEAR_DARK_CYC,
  parameter int NEAR_EMIT_CYC  = lpc_pkg::NEAR_EMIT_CYC,
  parameter int SLEEP_UNIT_CYC = lpc_pkg::SLEEP_UNIT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  input  wire logic [11:0] amb_visible_i,
  input  wire logic [11:0] amb_infrared_i,
  input  wire logic [7:0]  near_level_i,
  output logic             emitter_drive_pin_o,
  output logic             emitter_drive_level_o,
  output logic             ambient_gain_range_o,
  output logic             visible_infrared_select_o,
  output logic             power_down_o,
  output logic             int_n_o
);

  // Register state.
  logic [7:0]  sense_reg;
  logic [7:0]  intcfg_reg;
  logic [7:0]  near_lo_reg;
  logic [7:0]  near_hi_reg;
  logic [7:0]  amb_a_reg;
  logic [7:0]  amb_b_reg;
  logic [7:0]  amb_c_reg;
  logic [11:0] amb_res_reg;
  logic [7:0]  rdata_reg;
  logic        amb_flag_reg;
  logic        amb_flag_next;
  logic        near_flag_reg;
  logic        near_flag_next;
  logic        int_n_reg;

  // Synchroniser stages for the analog codes.
  logic [11:0] vis_s1_reg;
  logic [11:0] vis_s2_reg;
  logic [11:0] ir_s1_reg;
  logic [11:0] ir_s2_reg;
  logic [7:0]  near_s1_reg;
  logic [7:0]  near_s2_reg;

  // Ambient conversion timer.
  logic [31:0] amb_cnt_reg;
  logic [31:0] amb_cnt_next;
  logic        amb_done_reg;
  logic        amb_end;

  // Decoded fields and strobes.
  logic        amb_en;
  logic        near_en;
  logic        visir_sel;
  logic [2:0]  idle_code;
  logic        combine_and;
  logic [4:0]  amb_need;
  logic [4:0]  near_need;
  logic [11:0] amb_low;
  logic [11:0] amb_high;
  logic [11:0] amb_sample;
  logic        amb_outside;
  logic        wr_sense;
  logic        wr_intcfg;
  logic        wr_near_lo;
  logic        wr_near_hi;
  logic        wr_amb_a;
  logic        wr_amb_b;
  logic        wr_amb_c;
  logic        amb_flag_clr;
  logic        near_flag_clr;
  logic [7:0]  intcfg_view;
  logic [7:0]  rd_mux;

  // Proximity path.
  logic        near_done;
  logic [7:0]  near_result;
  logic        near_emit;
  logic        near_hi_hit;
  logic        near_lo_hit;
  logic        amb_hit;
  logic        int_active;

  // Field decode of the configuration registers.
  assign amb_en = sense_reg[lpc_pkg::CFG_AMB_EN];
  assign near_en = sense_reg[lpc_pkg::CFG_NEAR_EN];
  assign visir_sel = sense_reg[lpc_pkg::CFG_VISIR];
  assign idle_code = sense_reg[lpc_pkg::CFG_IDLE_LSB +: 3];
  assign combine_and = intcfg_reg[lpc_pkg::INT_COMBINE];
  assign amb_need = lpc_pkg::lpc_persist_need(intcfg_reg[lpc_pkg::INT_AMB_PRST_LSB +: 2]);
  assign near_need = lpc_pkg::lpc_persist_need(intcfg_reg[lpc_pkg::INT_NEAR_PRST_LSB +: 2]);

  // Ambient window: low limit in bytes a and low nibble of b, high limit above it.
  assign amb_low = {amb_b_reg[3:0], amb_a_reg};
  assign amb_high = {amb_c_reg, amb_b_reg[7:4]};

  // Write strobes per register.
  assign wr_sense = reg_wr_i && (reg_addr_i == lpc_pkg::OFS_SENSE);
  assign wr_intcfg = reg_wr_i && (reg_addr_i == lpc_pkg::OFS_INTCFG);
  assign wr_near_lo = reg_wr_i && (reg_addr_i == lpc_pkg::OFS_NEAR_LO);
  assign wr_near_hi = reg_wr_i && (reg_addr_i == lpc_pkg::OFS_NEAR_HI);
  assign wr_amb_a = reg_wr_i && (reg_addr_i == lpc_pkg::OFS_AMB_A);
  assign wr_amb_b = reg_wr_i && (reg_addr_i == lpc_pkg::OFS_AMB_B);
  assign wr_amb_c = reg_wr_i && (reg_addr_i == lpc_pkg::OFS_AMB_C);

  // Writing 0 to a flag clears it; writing 1 leaves it alone.
  assign amb_flag_clr = wr_intcfg && !reg_wdata_i[lpc_pkg::INT_AMB_FLAG];
  assign near_flag_clr = wr_intcfg && !reg_wdata_i[lpc_pkg::INT_NEAR_FLAG];

  // Configuration registers; the flag bits of the interrupt register live apart.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sense_reg <= lpc_pkg::REG_RESET;
      intcfg_reg <= lpc_pkg::REG_RESET;
      near_lo_reg <= lpc_pkg::REG_RESET;
      near_hi_reg <= lpc_pkg::REG_RESET;
    end else begin
      if (wr_sense) begin
        sense_reg <= reg_wdata_i;
      end
      if (wr_intcfg) begin
        intcfg_reg <= reg_wdata_i;
      end
      if (wr_near_lo) begin
        near_lo_reg <= reg_wdata_i;
      end
      if (wr_near_hi) begin
        near_hi_reg <= reg_wdata_i;
      end
    end
  end

  // Ambient threshold bytes.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      amb_a_reg <= lpc_pkg::REG_RESET;
      amb_b_reg <= lpc_pkg::REG_RESET;
      amb_c_reg <= lpc_pkg::REG_RESET;
    end else begin
      if (wr_amb_a) begin
        amb_a_reg <= reg_wdata_i;
      end
      if (wr_amb_b) begin
        amb_b_reg <= reg_wdata_i;
      end
      if (wr_amb_c) begin
        amb_c_reg <= reg_wdata_i;
      end
    end
  end

  // Two-stage synchronisers for the analog converter codes.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vis_s1_reg <= 12'h000;
      vis_s2_reg <= 12'h000;
      ir_s1_reg <= 12'h000;
      ir_s2_reg <= 12'h000;
      near_s1_reg <= 8'h00;
      near_s2_reg <= 8'h00;
    end else begin
      vis_s1_reg <= amb_visible_i;
      vis_s2_reg <= vis_s1_reg;
      ir_s1_reg <= amb_infrared_i;
      ir_s2_reg <= ir_s1_reg;
      near_s1_reg <= near_level_i;
      near_s2_reg <= near_s1_reg;
    end
  end

  // The one ambient converter sees visible or infrared light by the select.
  assign amb_sample = visir_sel ? ir_s2_reg : vis_s2_reg;

  // Free-running ambient timer, restarted whenever ambient sensing is off.
  assign amb_end = (amb_cnt_reg == 32'(AMB_CONV_CYC - 1));
  assign amb_cnt_next = (!amb_en || amb_end) ? 32'h0 : amb_cnt_reg + 32'h1;

  // Ambient conversion completes and stores its 12-bit result.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      amb_cnt_reg <= 32'h0;
      amb_done_reg <= 1'b0;
      amb_res_reg <= 12'h000;
    end else begin
      amb_cnt_reg <= amb_cnt_next;
      amb_done_reg <= amb_en && amb_end;
      if (amb_en && amb_end) begin
        amb_res_reg <= amb_sample;
      end
    end
  end

  // Window test on the result just stored, against current limits.
  assign amb_outside = (amb_res_reg < amb_low) || (amb_res_reg > amb_high);

  // Proximity measurement runs on its own timer, unrelated to the ambient one.
  lpc_near_seq #(
    .DARK_CYC (NEAR_DARK_CYC),
    .EMIT_CYC (NEAR_EMIT_CYC),
    .UNIT_CYC (SLEEP_UNIT_CYC)
  ) u_near_seq (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .enable_i    (near_en),
    .idle_code_i (idle_code),
    .level_i     (near_s2_reg),
    .emitter_o   (near_emit),
    .done_o      (near_done),
    .result_o    (near_result)
  );

  // Consecutive out-of-window ambient results.
  lpc_persist u_amb_persist (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .clear_i  (!amb_en),
    .event_i  (amb_done_reg),
    .cond_i   (amb_outside),
    .need_i   (amb_need),
    .hit_o    (amb_hit)
  );

  // Consecutive proximity results above the high limit.
  lpc_persist u_near_hi_persist (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .clear_i  (!near_en),
    .event_i  (near_done),
    .cond_i   (near_result > near_hi_reg),
    .need_i   (near_need),
    .hit_o    (near_hi_hit)
  );

  // Consecutive proximity results below the low limit.
  lpc_persist u_near_lo_persist (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .clear_i  (!near_en),
    .event_i  (near_done),
    .cond_i   (near_result < near_lo_reg),
    .need_i   (near_need),
    .hit_o    (near_lo_hit)
  );

  // Flag updates; a hardware set in the same cycle as a clear wins.
  assign amb_flag_next = amb_hit ? 1'b1 : (amb_flag_clr ? 1'b0 : amb_flag_reg);
  assign near_flag_next = near_hi_hit ? 1'b1 :
                          (near_lo_hit || near_flag_clr) ? 1'b0 : near_flag_reg;

  // Combined interrupt condition.
  assign int_active = combine_and ? (amb_flag_reg && near_flag_reg)
                                  : (amb_flag_reg || near_flag_reg);

  // Sticky flags and the registered active-low interrupt pin.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      amb_flag_reg <= 1'b0;
      near_flag_reg <= 1'b0;
      int_n_reg <= 1'b1;
    end else begin
      amb_flag_reg <= amb_flag_next;
      near_flag_reg <= near_flag_next;
      int_n_reg <= !int_active;
    end
  end

  // Interrupt register as read back, with the live flags in their places.
  always_comb begin
    intcfg_view = intcfg_reg;
    intcfg_view[lpc_pkg::INT_AMB_FLAG] = amb_flag_reg;
    intcfg_view[lpc_pkg::INT_NEAR_FLAG] = near_flag_reg;
  end

  // Read select; unmapped offsets read as zero.
  assign rd_mux = (reg_addr_i == lpc_pkg::OFS_SENSE)   ? sense_reg :
                  (reg_addr_i == lpc_pkg::OFS_INTCFG)  ? intcfg_view :
                  (reg_addr_i == lpc_pkg::OFS_NEAR_LO) ? near_lo_reg :
                  (reg_addr_i == lpc_pkg::OFS_NEAR_HI) ? near_hi_reg :
                  (reg_addr_i == lpc_pkg::OFS_AMB_A)   ? amb_a_reg :
                  (reg_addr_i == lpc_pkg::OFS_AMB_B)   ? amb_b_reg :
                  (reg_addr_i == lpc_pkg::OFS_AMB_C)   ? amb_c_reg :
                  (reg_addr_i == lpc_pkg::OFS_NEAR_RS) ? near_result :
                  (reg_addr_i == lpc_pkg::OFS_AMB_RL)  ? amb_res_reg[7:0] :
                  (reg_addr_i == lpc_pkg::OFS_AMB_RH)  ? {4'h0, amb_res_reg[11:8]} :
                  8'h00;

  // Read data is captured on the read strobe and held until the next one.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_reg <= rd_mux;
    end
  end

  // Output pins: read data, analog front-end controls and the interrupt.
  assign reg_rdata_o = rdata_reg;
  assign emitter_drive_pin_o = near_emit;
  assign emitter_drive_level_o = sense_reg[lpc_pkg::CFG_DRIVE];
  assign ambient_gain_range_o = sense_reg[lpc_pkg::CFG_RANGE];
  assign visible_infrared_select_o = visir_sel;
  assign power_down_o = !amb_en && !near_en;
  assign int_n_o = int_n_reg;

endmodule
`default_nettype wire

//--- core/lpc_pkg.sv
// Purpose: Shared constants and types of the light and proximity conversion core.
// Assumes: A 200 MHz core clock; register offsets are byte indices of the serial engine.
// Notes:   Long cycle counts are derived here and passed to the top as parameters.
`default_nettype none
package lpc_pkg;

  // Core clock rate.
  localparam int CLK_MHZ = 200;

  // Register offsets.
  localparam logic [7:0] OFS_SENSE   = 8'h01;
  localparam logic [7:0] OFS_INTCFG  = 8'h02;
  localparam logic [7:0] OFS_NEAR_LO = 8'h03;
  localparam logic [7:0] OFS_NEAR_HI = 8'h04;
  localparam logic [7:0] OFS_AMB_A   = 8'h05;
  localparam logic [7:0] OFS_AMB_B   = 8'h06;
  localparam logic [7:0] OFS_AMB_C   = 8'h07;
  localparam logic [7:0] OFS_NEAR_RS = 8'h08;
  localparam logic [7:0] OFS_AMB_RL  = 8'h09;
  localparam logic [7:0] OFS_AMB_RH  = 8'h0a;

  // Field positions of the sensing configuration register.
  localparam int CFG_NEAR_EN = 7;
  localparam int CFG_IDLE_LSB = 4;
  localparam int CFG_DRIVE = 3;
  localparam int CFG_AMB_EN = 2;
  localparam int CFG_RANGE = 1;
  localparam int CFG_VISIR = 0;

  // Field positions of the interrupt configuration register.
  localparam int INT_NEAR_FLAG = 7;
  localparam int INT_NEAR_PRST_LSB = 5;
  localparam int INT_AMB_FLAG = 3;
  localparam int INT_AMB_PRST_LSB = 1;
  localparam int INT_COMBINE = 0;

  // Reset value of every register.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Timing in microseconds and the derived cycle counts.
  localparam int AMB_CONV_US = 100000;
  localparam int NEAR_MEAS_US = 540;
  localparam int NEAR_EMIT_US = 100;
  localparam int NEAR_DARK_US = (NEAR_MEAS_US - NEAR_EMIT_US) / 2;
  localparam int SLEEP_UNIT_US = 500;
  localparam int AMB_CONV_CYC = AMB_CONV_US * CLK_MHZ;
  localparam int NEAR_EMIT_CYC = NEAR_EMIT_US * CLK_MHZ;
  localparam int NEAR_DARK_CYC = NEAR_DARK_US * CLK_MHZ;
  localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_US * CLK_MHZ;

  // Phases of one proximity measurement.
  typedef enum logic [1:0] {
    LPC_NS_SLEEP = 2'b00,
    LPC_NS_DARK  = 2'b01,
    LPC_NS_LIT   = 2'b10,
    LPC_NS_TAIL  = 2'b11
  } lpc_near_state_t;

  // Consecutive events needed for a two-bit persistence code: 1, 4, 8 or 16.
  function automatic logic [4:0] lpc_persist_need(input logic [1:0] code);
    case (code)
      2'h0:    lpc_persist_need = 5'h01;
      2'h1:    lpc_persist_need = 5'h04;
      2'h2:    lpc_persist_need = 5'h08;
      default: lpc_persist_need = 5'h10;
    endcase
  endfunction

  // Idle time between proximity measurements, in sleep units.
  function automatic logic [11:0] lpc_sleep_units(input logic [2:0] code);
    case (code)
      3'h0:    lpc_sleep_units = 12'h640;
      3'h1:    lpc_sleep_units = 12'h320;
      3'h2:    lpc_sleep_units = 12'h190;
      3'h3:    lpc_sleep_units = 12'h0c8;
      3'h4:    lpc_sleep_units = 12'h096;
      3'h5:    lpc_sleep_units = 12'h064;
      3'h6:    lpc_sleep_units = 12'h019;
      default: lpc_sleep_units = 12'h000;
    endcase
  endfunction

endpackage
`default_nettype wire

//--- core/lpc_persist.sv
// Purpose: Counts strictly consecutive conversions that meet a condition.
// Assumes: event_i is a one-cycle pulse per completed conversion.
// Notes:   hit_o pulses for every event once the run length reaches need_i.
`timescale 1ns/10ps
`default_nettype none
module lpc_persist (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       clear_i,
  input  wire logic       event_i,
  input  wire logic       cond_i,
  input  wire logic [4:0] need_i,
  output logic            hit_o
);

  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic       hit_reg;
  logic       hit_next;

  // A miss restarts the run; the run saturates at the needed length.
  assign cnt_next = clear_i ? 5'h00 :
                    !event_i ? cnt_reg :
                    !cond_i ? 5'h00 :
                    (cnt_reg >= need_i) ? need_i : cnt_reg + 5'h01;
  assign hit_next = event_i && cond_i && !clear_i && (cnt_next >= need_i);

  // Run counter and hit pulse.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 5'h00;
      hit_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      hit_reg <= hit_next;
    end
  end

  assign hit_o = hit_reg;

endmodule
`default_nettype wire

//--- core/lpc_near_seq.sv
// Purpose: Sequences proximity measurements: dark sample, emitter pulse, lit sample, sleep.
// Assumes: level_i is already synchronised to clk_i.
// Notes:   The first measurement starts on the cycle after enable_i rises.
`timescale 1ns/10ps
`default_nettype none
module lpc_near_seq #(
  parameter int DARK_CYC = 4,
  parameter int EMIT_CYC = 2,
  parameter int UNIT_CYC = 8
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       enable_i,
  input  wire logic [2:0] idle_code_i,
  input  wire logic [7:0] level_i,
  output logic            emitter_o,
  output logic            done_o,
  output logic [7:0]      result_o
);

  lpc_pkg::lpc_near_state_t state_reg;
  lpc_pkg::lpc_near_state_t state_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic [7:0]  dark_reg;
  logic [7:0]  res_reg;
  logic        emit_reg;
  logic        done_reg;
  logic        last;
  logic [31:0] sleep_cyc;

  assign last = (cnt_reg == 32'h0);
  assign sleep_cyc = 32'(lpc_pkg::lpc_sleep_units(idle_code_i)) * 32'(UNIT_CYC);

  // Phase stepping; each phase ends when its down-counter reaches zero.
  always_comb begin
    state_next = state_reg;
    cnt_next = last ? 32'h0 : cnt_reg - 32'h1;
    if (!enable_i) begin
      state_next = lpc_pkg::LPC_NS_SLEEP;
      cnt_next = 32'h0;
    end else if (last) begin
      case (state_reg)
        lpc_pkg::LPC_NS_SLEEP: begin
          state_next = lpc_pkg::LPC_NS_DARK;
          cnt_next = 32'(DARK_CYC - 1);
        end
        lpc_pkg::LPC_NS_DARK: begin
          state_next = lpc_pkg::LPC_NS_LIT;
          cnt_next = 32'(EMIT_CYC - 1);
        end
        lpc_pkg::LPC_NS_LIT: begin
          state_next = lpc_pkg::LPC_NS_TAIL;
          cnt_next = 32'(DARK_CYC - 1);
        end
        default: begin
          state_next = lpc_pkg::LPC_NS_SLEEP;
          cnt_next = sleep_cyc;
        end
      endcase
    end
  end

  // State, counter, samples, emitter drive and result.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= lpc_pkg::LPC_NS_SLEEP;
      cnt_reg <= 32'h0;
      dark_reg <= 8'h00;
      res_reg <= 8'h00;
      emit_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      emit_reg <= (state_next == lpc_pkg::LPC_NS_LIT);
      done_reg <= enable_i && last && (state_reg == lpc_pkg::LPC_NS_LIT);
      if (enable_i && last && state_reg == lpc_pkg::LPC_NS_DARK) begin
        dark_reg <= level_i;
      end
      if (enable_i && last && state_reg == lpc_pkg::LPC_NS_LIT) begin
        res_reg <= (level_i > dark_reg) ? level_i - dark_reg : 8'h00;
      end
    end
  end

  assign emitter_o = emit_reg;
  assign done_o = done_reg;
  assign result_o = res_reg;

endmodule
`default_nettype wire

//--- test/lpc_sensor_sva.sv
// Purpose: Port checker of the light and proximity conversion core.
// Assumes: Bound to lpc_sensor_core; one clock domain.
// Notes:   The emitter pulse length is counted in helper logic.
`timescale 1ns/10ps
`default_nettype none
module lpc_sensor_sva #(
  parameter int NEAR_EMIT_CYC = 2
) (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       emitter_drive_pin_o,
  input wire logic       emitter_drive_level_o,
  input wire logic       visible_infrared_select_o,
  input wire logic       power_down_o,
  input wire logic       int_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [15:0] emit_cnt_reg;
  // Decoded host writes.
  wire sense_wr = reg_wr_i && (reg_addr_i == 8'h01);
  wire flag_clr = reg_wr_i && (reg_addr_i == 8'h02) && !reg_wdata_i[7] && !reg_wdata_i[3];
  // Counts the cycles for which the emitter has stood high.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      emit_cnt_reg <= 16'h0000;
    end else if (emitter_drive_pin_o) begin
      emit_cnt_reg <= emit_cnt_reg + 16'h0001;
    end else begin
      emit_cnt_reg <= 16'h0000;
    end
  end
  // A limit write followed by its read back, and a flag clear while powered down.
  sequence s_limit_wr_rd;
    reg_wr_i && (reg_addr_i == 8'h03) ##2 reg_rd_i && (reg_addr_i == 8'h03);
  endsequence
  sequence s_quiet_clear;
    power_down_o [*4] ##0 flag_clr ##1 power_down_o [*2];
  endsequence
  AST_EMIT_LEN: assert property ($fell(emitter_drive_pin_o) |-> emit_cnt_reg == NEAR_EMIT_CYC)
    else $error("emitter pulse length wrong");
  AST_DRIVE_LVL: assert property (sense_wr |=> emitter_drive_level_o == $past(reg_wdata_i[3]))
    else $error("drive level does not follow its bit");
  AST_VISIR: assert property (sense_wr |=> visible_infrared_select_o == $past(reg_wdata_i[0]))
    else $error("sensing select does not follow its bit");
  AST_PWRDN: assert property (sense_wr |=> power_down_o == !($past(reg_wdata_i[7]) || $past(reg_wdata_i[2])))
    else $error("power down does not follow the enables");
  AST_EMIT_OFF: assert property (sense_wr && !reg_wdata_i[7] |=> ##1 !emitter_drive_pin_o)
    else $error("emitter still on after proximity disable");
  AST_RD_UNMAP: assert property (reg_rd_i && (reg_addr_i > 8'h0a) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_BACK: assert property (s_limit_wr_rd |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("limit read back wrong");
  AST_INT_CLEAR: assert property (s_quiet_clear |-> int_n_o)
    else $error("interrupt still low after flag clear");
endmodule
bind lpc_sensor_core lpc_sensor_sva #(.NEAR_EMIT_CYC(NEAR_EMIT_CYC)) u_sva (
  .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .emitter_drive_pin_o(emitter_drive_pin_o),
  .emitter_drive_level_o(emitter_drive_level_o), .visible_infrared_select_o(visible_infrared_select_o),
  .power_down_o(power_down_o), .int_n_o(int_n_o));
`default_nettype wire

//--- test/lpc_host_model.sv
// Purpose: Host side of the register port.
// Assumes: Requests start 1 ns after a rising edge.
// Notes:   Idle address and data show the inverse of the last value.
`timescale 1ns/10ps
`default_nettype none
module lpc_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output var logic [7:0]  addr_o,
  output var logic        wr_o,
  output var logic        rd_o,
  output var logic [7:0]  wdata_o
);
  // Idle levels at time zero.
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // Writes one byte with a one-cycle strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // Reads one byte; the data is taken one cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Purpose: Self-checking bench of the light and proximity conversion core.
// Assumes: Shortened counts; every register access goes through the host model.
// Notes:   The proximity level follows the emitter, so each proximity result is 0x60.
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int AMB = 200;
  localparam int DARK = 4;
  localparam int UNIT = 3;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  addr, wdata, rdata;
  logic        wr, rd, emit, lvl, rng, sel, pd, int_n;
  logic [11:0] vis = 12'h123;
  logic [11:0] ir = 12'h456;
  logic [7:0]  near = 8'h10;
  int          fail_count = 0;
  int          num_checks = 0;
  int          n;
  int          units [8] = '{1600, 800, 400, 200, 150, 100, 25, 0};
  // Clock of 5 ns.
  always #2.5 clk_i = ~clk_i;
  // Reflected level is bright while the emitter is on; the pulse outlasts the two-stage sync delay.
  always @(posedge clk_i) #1 near = emit ? 8'h70 : 8'h10;
  // Design and host.
  lpc_sensor_core #(.AMB_CONV_CYC(AMB), .NEAR_DARK_CYC(DARK), .NEAR_EMIT_CYC(4), .SLEEP_UNIT_CYC(UNIT)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .amb_visible_i(vis), .amb_infrared_i(ir), .near_level_i(near),
    .emitter_drive_pin_o(emit), .emitter_drive_level_o(lvl), .ambient_gain_range_o(rng),
    .visible_infrared_select_o(sel), .power_down_o(pd), .int_n_o(int_n));
  lpc_host_model host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  // Comparison, waits and the closing verdict.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v);
    check({8'h00, v}, {8'h00, e});
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task automatic gap(output int g);
    g = 0;
    while (emit !== 1'b1) cyc(1);
    while (emit !== 1'b0) cyc(1);
    while (emit !== 1'b1) begin
      cyc(1);
      g++;
    end
  endtask
  task automatic results;
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    results();
  end
  // Test sequence.
  initial begin
    cyc(20);
    resetn_i = 1'b1;
    for (int a = 1; a < 12; a++) rdc(a[7:0], 8'h00);
    host.wr(8'h03, 8'ha5);
    rdc(8'h03, 8'ha5);
    host.wr(8'h04, 8'h5a);
    rdc(8'h04, 8'h5a);
    host.wr(8'h08, 8'hff);
    rdc(8'h08, 8'h00);
    host.wr(8'h02, 8'hff);
    rdc(8'h02, 8'h77);
    host.wr(8'h02, 8'h00);
    host.wr(8'h01, 8'h0b);
    check({12'h000, lvl, rng, sel, pd}, 16'h000f);
    host.wr(8'h05, 8'h00);
    host.wr(8'h06, 8'h01);
    host.wr(8'h07, 8'h20);
    host.wr(8'h01, 8'h04);
    check({12'h000, lvl, rng, sel, pd}, 16'h0000);
    cyc(AMB + 5);
    rdc(8'h09, 8'h23);
    rdc(8'h0a, 8'h01);
    rdc(8'h02, 8'h00);
    host.wr(8'h01, 8'h00);
    host.wr(8'h02, 8'h02);
    host.wr(8'h01, 8'h05);
    cyc(500);
    ir = 12'h150;
    cyc(200);
    ir = 12'h456;
    cyc(580);
    rdc(8'h02, 8'h02);
    cyc(130);
    rdc(8'h02, 8'h0a);
    check({15'h0000, int_n}, 16'h0000);
    rdc(8'h09, 8'h56);
    rdc(8'h0a, 8'h04);
    host.wr(8'h02, 8'h0b);
    cyc(2);
    check({15'h0000, int_n}, 16'h0001);
    host.wr(8'h01, 8'h00);
    cyc(5);
    host.wr(8'h02, 8'h00);
    cyc(2);
    check({15'h0000, int_n}, 16'h0001);
    rdc(8'h02, 8'h00);
    for (int c = 0; c < 8; c++) begin
      host.wr(8'h01, {1'b1, c[2:0], 4'h0});
      gap(n);
      check(16'(n), 16'(2 * DARK + 1 + units[c] * UNIT));
    end
    rdc(8'h08, 8'h60);
    rdc(8'h02, 8'h80);
    vis = 12'h7d0;
    host.wr(8'h01, 8'h04);
    cyc(AMB + 5);
    rdc(8'h0a, 8'h07);
    host.wr(8'h01, 8'h06);
    check({15'h0000, rng}, 16'h0001);
    cyc(AMB + 5);
    rdc(8'h09, 8'hd0);
    host.wr(8'h01, 8'h00);
    results();
  end
endmodule
`default_nettype wire
